/* verilog/mtd_defines.svh */
// Purpose: Constants of the tone decoder: offsets, reset values, limits, timing
// Assumes: Included by bare name from the package and the design files
// Notes: Definitions only
`ifndef MTD_DEFINES_SVH
`define MTD_DEFINES_SVH

// Register byte offsets
`define MTD_OFF_CTRL 8'h00
`define MTD_OFF_MODE 8'h04
`define MTD_OFF_BLANK 8'h08
`define MTD_OFF_SPDAVG 8'h0c
`define MTD_OFF_AMPAVG 8'h10
`define MTD_OFF_WPM 8'h14
`define MTD_OFF_STATUS 8'h18
`define MTD_OFF_THRESH 8'h1c
`define MTD_OFF_AMPL 8'h20
`define MTD_OFF_DOT 8'h24

// Field positions
`define MTD_CTRL_RX_EN 0
`define MTD_CTRL_TX_EN 1
`define MTD_CTRL_EDIT_EN 2
`define MTD_MODE_TX_ACT 0
`define MTD_MODE_EDIT_ACT 1
`define MTD_STAT_TONE 0
`define MTD_STAT_LINE 1
`define MTD_STAT_OVF 2
`define MTD_STAT_PEND 3

// Reset values
`define MTD_RST_CTRL 3'h7
`define MTD_RST_MODE 2'h0
`define MTD_RST_BLANK 8'h0a
`define MTD_RST_SPDAVG 8'h07
`define MTD_RST_AMPAVG 8'h3c
`define MTD_RST_WPM 8'h14

// Legal ranges of settings
`define MTD_BLANK_MAX 8'h63
`define MTD_AVG_MIN 8'h01
`define MTD_AVG_MAX 8'h63
`define MTD_WPM_MIN 8'h01
`define MTD_WPM_MAX 8'h63

// Detector and timing
`define MTD_BLOCK_LEN 6'h30
`define MTD_TICK_MS 24'h000004
`define MTD_GOERTZEL_COEF 16'h7787
`define MTD_COEF_SHIFT 14
`define MTD_SMP_MID 11'h200
`define MTD_DOT_MS_WPM 24'h0004b0
`define MTD_CHAR_GAP_MUL 3'h2
`define MTD_WORD_GAP_MUL 3'h5
`define MTD_CODE_SPACE 8'h01
`define MTD_FIFO_DEPTH 4

`endif

/* verilog/mtd_pkg.sv */
// Purpose: Types shared by the tone decoder files
// Assumes: mtd_defines.svh holds all numbers
// Notes: Character code is a marker bit followed by elements, 1 for long
`include "mtd_defines.svh"
package mtd_pkg;

    // Decoded character toward the display or parameter editor
    typedef struct packed {
        logic edit;
        logic [7:0] code;
    } mtd_chr_t;

    // Classic bus request
    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } mtd_wb_req_t;

    // Keying line state
    typedef enum logic {
        MTD_LN_GAP,
        MTD_LN_TONE
    } mtd_line_t;

endpackage : mtd_pkg

/* verilog/mtd_fifo.sv */
// Purpose: Small FIFO with valid and ready on both sides
// Assumes: Single clock, DEPTH a power of two
// Notes: Read data come straight out of the storage flops
`timescale 1ns/10ps
`default_nettype none
module mtd_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Fill side
    input wire logic i_in_valid,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_in_ready,
    // Drain side
    output logic o_out_valid,
    output logic [WIDTH-1:0] o_out_data,
    input wire logic i_out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] cnt_reg;
    logic push;
    logic pop;

    assign o_in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_reg != '0);
    assign o_out_data = mem_reg[rd_ptr_reg];
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    ////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_reg[i] <= '0;
            end
        end else if (push) begin
            mem_reg[wr_ptr_reg] <= i_in_data;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 1'b1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 1'b1;
            end
        end
    end

endmodule : mtd_fifo
`default_nettype wire

/* verilog/mtd_decoder.sv */
// Purpose: Morse tone decoder: tone bin, adaptive threshold, timing, characters
// Assumes: Sample strobes at least two clocks apart, same clock domain
// Notes: Characters leave as marker-coded element patterns through a FIFO
//
// Implementation choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "mtd_defines.svh"

module mtd_decoder (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Audio samples
    input wire logic i_smp_valid,
    input wire logic [9:0] i_smp_data,
    // Operator key pin
    input wire logic i_key_down,
    // Character stream
    output logic o_chr_valid,
    output mtd_pkg::mtd_chr_t o_chr,
    input wire logic i_chr_ready,
    // Wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack
);
    import mtd_pkg::*;

    function automatic logic [7:0] clamp8(input logic [7:0] v, input logic [7:0] lo,
                                          input logic [7:0] hi);
        logic [7:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction : clamp8

    // Truncating step keeps integer EMA within one weight of its target
    function automatic logic [23:0] ema(input logic [23:0] avg, input logic [23:0] smp,
                                        input logic [7:0] wt);
        logic signed [25:0] d;
        logic signed [25:0] w;
        logic signed [25:0] r;
        d = $signed({2'b00, smp}) - $signed({2'b00, avg});
        w = $signed({18'h00000, wt});
        r = $signed({2'b00, avg}) + d / w;
        return r[23:0];
    endfunction : ema

    function automatic logic [23:0] sat_add(input logic [23:0] a, input logic [23:0] b);
        logic [24:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[24] ? 24'hffffff : s[23:0];
    endfunction : sat_add

    ////////////////////////////////////////////////////////////////////
    // Register file
    logic [2:0] ctrl_reg;
    logic [1:0] mode_reg;
    logic [7:0] blank_reg;
    logic [7:0] spdavg_reg;
    logic [7:0] ampavg_reg;
    logic [7:0] wpm_reg;
    logic ovf_reg;
    logic ack_reg;
    logic [31:0] rdat_reg;
    logic [31:0] rdat_next;
    logic wb_req;
    logic wb_wr;
    logic ovf_set;

    assign wb_req = i_wb_cyc && i_wb_stb && !ack_reg;
    assign wb_wr = wb_req && i_wb_we && i_wb_sel[0];
    assign o_wb_ack = ack_reg;
    assign o_wb_dat = rdat_reg;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctrl_reg <= `MTD_RST_CTRL;
            mode_reg <= `MTD_RST_MODE;
            blank_reg <= `MTD_RST_BLANK;
            spdavg_reg <= `MTD_RST_SPDAVG;
            ampavg_reg <= `MTD_RST_AMPAVG;
            wpm_reg <= `MTD_RST_WPM;
        end else if (wb_wr) begin
            if (i_wb_adr == `MTD_OFF_CTRL) begin
                ctrl_reg <= i_wb_dat[2:0];
            end else if (i_wb_adr == `MTD_OFF_MODE) begin
                mode_reg <= i_wb_dat[1:0];
            end else if (i_wb_adr == `MTD_OFF_BLANK) begin
                blank_reg <= i_wb_dat[7:0];
            end else if (i_wb_adr == `MTD_OFF_SPDAVG) begin
                spdavg_reg <= i_wb_dat[7:0];
            end else if (i_wb_adr == `MTD_OFF_AMPAVG) begin
                ampavg_reg <= i_wb_dat[7:0];
            end else if (i_wb_adr == `MTD_OFF_WPM) begin
                wpm_reg <= i_wb_dat[7:0];
            end
        end
    end

    // Overflow is sticky; a new event beats a write-one clear
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ovf_reg <= 1'b0;
        end else if (ovf_set) begin
            ovf_reg <= 1'b1;
        end else if (wb_wr && i_wb_adr == `MTD_OFF_STATUS && i_wb_dat[`MTD_STAT_OVF]) begin
            ovf_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Settings in use
    logic [7:0] blank_ms;
    logic [7:0] spd_wt;
    logic [7:0] amp_wt;
    logic [7:0] wpm_use;

    assign blank_ms = clamp8(blank_reg, 8'h00, `MTD_BLANK_MAX);
    assign spd_wt = clamp8(spdavg_reg, `MTD_AVG_MIN, `MTD_AVG_MAX);
    assign amp_wt = clamp8(ampavg_reg, `MTD_AVG_MIN, `MTD_AVG_MAX);
    assign wpm_use = clamp8(wpm_reg, `MTD_WPM_MIN, `MTD_WPM_MAX);

    ////////////////////////////////////////////////////////////////////
    // Key pin synchroniser
    logic key_meta_reg;
    logic key_sync_reg;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            key_meta_reg <= 1'b0;
            key_sync_reg <= 1'b0;
        end else begin
            key_meta_reg <= i_key_down;
            key_sync_reg <= key_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Single-bin tone detector
    logic [5:0] smp_cnt_reg;
    logic signed [23:0] s1_reg;
    logic signed [23:0] s2_reg;
    logic blk_done_reg;
    logic tick_reg;
    logic [23:0] ampl_reg;
    logic signed [10:0] x_s;
    logic signed [39:0] cs1;
    logic signed [39:0] s0_w;
    logic signed [47:0] mag2;

    assign x_s = $signed({1'b0, i_smp_data}) - $signed(`MTD_SMP_MID);
    assign cs1 = $signed(`MTD_GOERTZEL_COEF) * s1_reg;
    assign s0_w = (cs1 >>> `MTD_COEF_SHIFT) + 40'(x_s) - 40'(s2_reg);
    assign mag2 = 48'(s1_reg * s1_reg) + 48'(s2_reg * s2_reg)
                  - 48'((cs1 >>> `MTD_COEF_SHIFT) * 40'(s2_reg));

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            smp_cnt_reg <= 6'h00;
            s1_reg <= '0;
            s2_reg <= '0;
            blk_done_reg <= 1'b0;
        end else begin
            blk_done_reg <= 1'b0;
            if (blk_done_reg) begin
                s1_reg <= '0;
                s2_reg <= '0;
            end else if (i_smp_valid) begin
                s1_reg <= s0_w[23:0];
                s2_reg <= s1_reg;
                if (smp_cnt_reg == `MTD_BLOCK_LEN - 6'h01) begin
                    smp_cnt_reg <= 6'h00;
                    blk_done_reg <= 1'b1;
                end else begin
                    smp_cnt_reg <= smp_cnt_reg + 6'h01;
                end
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ampl_reg <= '0;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= blk_done_reg;
            if (blk_done_reg) begin
                ampl_reg <= mag2[47] ? 24'h000000 : mag2[31:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Threshold and tone decision
    logic [23:0] thr_reg;
    logic busy_act;
    logic tone_now;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            thr_reg <= '0;
        end else if (tick_reg) begin
            thr_reg <= ema(thr_reg, ampl_reg, amp_wt);
        end
    end

    assign busy_act = mode_reg[`MTD_MODE_TX_ACT] || mode_reg[`MTD_MODE_EDIT_ACT];
    assign tone_now = busy_act ? key_sync_reg : (ampl_reg > thr_reg);

    ////////////////////////////////////////////////////////////////////
    // Timing and element classification
    mtd_line_t line_reg;
    logic [23:0] tone_ms_reg;
    logic [23:0] gap_ms_reg;
    logic [23:0] dot_reg;
    logic [7:0] pat_reg;
    logic word_pend_reg;
    logic busy_prev_reg;
    logic elem_end;
    logic is_dash;
    logic char_gap;
    logic word_gap;
    logic seed;

    assign elem_end = tick_reg && line_reg == MTD_LN_TONE && !tone_now
                      && tone_ms_reg >= {16'h0000, blank_ms};
    assign is_dash = tone_ms_reg > (dot_reg << 1);
    assign char_gap = tick_reg && line_reg == MTD_LN_GAP && !tone_now && pat_reg != 8'h01
                      && gap_ms_reg >= 24'(dot_reg * `MTD_CHAR_GAP_MUL);
    assign word_gap = tick_reg && line_reg == MTD_LN_GAP && !tone_now && !char_gap
                      && word_pend_reg && gap_ms_reg >= 24'(dot_reg * `MTD_WORD_GAP_MUL);
    assign seed = busy_act && !busy_prev_reg;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            line_reg <= MTD_LN_GAP;
            tone_ms_reg <= '0;
        end else if (tick_reg) begin
            case (line_reg)
                MTD_LN_GAP: begin
                    if (tone_now) begin
                        line_reg <= MTD_LN_TONE;
                        tone_ms_reg <= `MTD_TICK_MS;
                    end
                end
                MTD_LN_TONE: begin
                    if (tone_now) begin
                        tone_ms_reg <= sat_add(tone_ms_reg, `MTD_TICK_MS);
                    end else begin
                        line_reg <= MTD_LN_GAP;
                    end
                end
                default: begin
                    line_reg <= MTD_LN_GAP;
                end
            endcase
        end
    end

    // blanked pulse leaves the gap running
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gap_ms_reg <= '0;
        end else if (elem_end) begin
            gap_ms_reg <= '0;
        end else if (tick_reg) begin
            gap_ms_reg <= sat_add(gap_ms_reg, `MTD_TICK_MS);
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pat_reg <= 8'h01;
            word_pend_reg <= 1'b0;
        end else if (elem_end) begin
            if (!pat_reg[7]) begin
                pat_reg <= {pat_reg[6:0], is_dash};
            end
        end else if (char_gap) begin
            pat_reg <= 8'h01;
            word_pend_reg <= 1'b1;
        end else if (word_gap) begin
            word_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            busy_prev_reg <= 1'b0;
            dot_reg <= `MTD_DOT_MS_WPM / 24'(`MTD_RST_WPM);
        end else begin
            busy_prev_reg <= busy_act;
            if (seed) begin
                dot_reg <= `MTD_DOT_MS_WPM / {16'h0000, wpm_use};
            end else if (elem_end) begin
                dot_reg <= ema(dot_reg, is_dash ? tone_ms_reg / 24'h000003 : tone_ms_reg,
                               spd_wt);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Character delivery
    logic out_ok;
    logic out_edit;
    logic emit;
    logic pend_valid_reg;
    mtd_chr_t pend_reg;
    logic fifo_ready;

    assign out_edit = mode_reg[`MTD_MODE_EDIT_ACT];
    assign out_ok = out_edit ? ctrl_reg[`MTD_CTRL_EDIT_EN]
                  : mode_reg[`MTD_MODE_TX_ACT] ? ctrl_reg[`MTD_CTRL_TX_EN]
                  : ctrl_reg[`MTD_CTRL_RX_EN];
    assign emit = (char_gap || word_gap) && out_ok;
    // A stalled display drops every new character while one is held
    assign ovf_set = emit && pend_valid_reg && !fifo_ready;

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pend_valid_reg <= 1'b0;
            pend_reg <= '0;
        end else if (emit && !(pend_valid_reg && !fifo_ready)) begin
            pend_valid_reg <= 1'b1;
            pend_reg.edit <= out_edit;
            pend_reg.code <= char_gap ? pat_reg : `MTD_CODE_SPACE;
        end else if (fifo_ready) begin
            pend_valid_reg <= 1'b0;
        end
    end

    mtd_fifo #(
        .WIDTH($bits(mtd_chr_t)),
        .DEPTH(`MTD_FIFO_DEPTH)
    ) u_fifo (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_in_valid(pend_valid_reg),
        .i_in_data(pend_reg),
        .o_in_ready(fifo_ready),
        .o_out_valid(o_chr_valid),
        .o_out_data(o_chr),
        .i_out_ready(i_chr_ready)
    );

    ////////////////////////////////////////////////////////////////////
    // Read mux and acknowledge
    always_comb begin
        rdat_next = 32'h00000000;
        if (i_wb_adr == `MTD_OFF_CTRL) begin
            rdat_next = {29'h0, ctrl_reg};
        end else if (i_wb_adr == `MTD_OFF_MODE) begin
            rdat_next = {30'h0, mode_reg};
        end else if (i_wb_adr == `MTD_OFF_BLANK) begin
            rdat_next = {24'h0, blank_reg};
        end else if (i_wb_adr == `MTD_OFF_SPDAVG) begin
            rdat_next = {24'h0, spdavg_reg};
        end else if (i_wb_adr == `MTD_OFF_AMPAVG) begin
            rdat_next = {24'h0, ampavg_reg};
        end else if (i_wb_adr == `MTD_OFF_WPM) begin
            rdat_next = {24'h0, wpm_reg};
        end else if (i_wb_adr == `MTD_OFF_STATUS) begin
            rdat_next = {28'h0, pend_valid_reg, ovf_reg, line_reg == MTD_LN_TONE, tone_now};
        end else if (i_wb_adr == `MTD_OFF_THRESH) begin
            rdat_next = {8'h0, thr_reg};
        end else if (i_wb_adr == `MTD_OFF_AMPL) begin
            rdat_next = {8'h0, ampl_reg};
        end else if (i_wb_adr == `MTD_OFF_DOT) begin
            rdat_next = {8'h0, dot_reg};
        end
    end

    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h00000000;
        end else begin
            ack_reg <= wb_req;
            if (wb_req && !i_wb_we) begin
                rdat_reg <= rdat_next;
            end
        end
    end

endmodule : mtd_decoder
`default_nettype wire

/* dv/mtd_decoder_checker.sv */
// Purpose: Concurrent checks on the tone decoder ports
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to every decoder instance
`timescale 1ns/10ps
`default_nettype none
module mtd_decoder_checker (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Samples and key
    input wire logic i_smp_valid,
    input wire logic [9:0] i_smp_data,
    input wire logic i_key_down,
    // Characters
    input wire logic o_chr_valid,
    input wire mtd_pkg::mtd_chr_t o_chr,
    input wire logic i_chr_ready,
    // Register bus
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack
);
    import mtd_pkg::*;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////
    property p_ack_next;
        i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("request not answered");
    property p_ack_cause;
        !(i_wb_cyc && i_wb_stb && !o_wb_ack) |=> !o_wb_ack;
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_ack_once;
        o_wb_ack |=> !o_wb_ack;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack held too long");
    property p_unmapped;
        i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack && i_wb_adr > 8'h27 |=> o_wb_dat == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_dat_hold;
        !(i_wb_cyc && i_wb_stb && !i_wb_we && !o_wb_ack) |=> $stable(o_wb_dat);
    endproperty
    a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
    ////////////////////////////////////////
    // Stalled consumer must see the same character
    property p_chr_hold;
        o_chr_valid && !i_chr_ready |=> o_chr_valid && $stable(o_chr);
    endproperty
    a_chr_hold: assert property (p_chr_hold) else $error("character lost while stalled");
    property p_chr_marker;
        o_chr_valid |-> o_chr.code != 8'h00;
    endproperty
    a_chr_marker: assert property (p_chr_marker) else $error("character without marker");
    property p_chr_fall;
        $fell(o_chr_valid) |-> $past(i_chr_ready);
    endproperty
    a_chr_fall: assert property (p_chr_fall) else $error("valid dropped without pop");
endmodule : mtd_decoder_checker
bind mtd_decoder mtd_decoder_checker u_chk (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_smp_valid(i_smp_valid), .i_smp_data(i_smp_data), .i_key_down(i_key_down),
    .o_chr_valid(o_chr_valid), .o_chr(o_chr), .i_chr_ready(i_chr_ready),
    .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr),
    .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack));
`default_nettype wire

/* dv/mtd_audio_model.sv */
// Purpose: Audio converter feeding receiver samples
// Assumes: One sample every 2 clocks, far faster than real rate
// Notes: Tone near the bin centre, small wobble when off
`timescale 1ns/10ps
`default_nettype none
module mtd_audio_model (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // Control
    input wire logic i_tone_on,
    // Converter output
    output logic o_smp_valid,
    output logic [9:0] o_smp_data
);
    real ph;
    logic [9:0] last_smp;
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_smp_valid <= 1'b0;
            o_smp_data <= 10'h200;
            last_smp = 10'h200;
            ph = 0.0;
        end else if (!o_smp_valid) begin
            ph = ph + 0.3665;
            last_smp = i_tone_on ? 10'(512 + $rtoi(400.0 * $sin(ph))) :
                (last_smp[0] ? 10'h1fe : 10'h203);
            o_smp_valid <= 1'b1;
            o_smp_data <= last_smp;
        end else begin
            // Data not held past the strobe
            o_smp_valid <= 1'b0;
            o_smp_data <= ~last_smp;
        end
    end
endmodule : mtd_audio_model
`default_nettype wire

/* dv/mtd_decoder_bench.sv */
// Purpose: Self-checking bench of the tone decoder
// Assumes: Samples every 2 clocks, so one 4 ms tick is 96 clocks
// Notes: Character queue model compared at every pop
`timescale 1ns/10ps
`default_nettype none
`include "mtd_defines.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin n_mismatch++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module mtd_decoder_bench;
    import mtd_pkg::*;
    localparam int TICK = 96;
    logic i_mclk = 0, i_rst_n = 0, i_key_down = 0, i_chr_ready = 0, tone = 0, hold = 0;
    logic i_wb_cyc = 0, i_wb_stb = 0, i_wb_we = 0;
    logic [7:0] i_wb_adr = 0;
    logic [3:0] i_wb_sel = 0;
    logic [31:0] i_wb_dat = 0, o_wb_dat, q;
    logic o_wb_ack, o_chr_valid;
    mtd_chr_t o_chr;
    wire logic smp_valid;
    wire logic [9:0] smp_data;
    int n_mismatch = 0, checks_done = 0, seed = 32'h194870b6, cycles = 0;
    logic [8:0] exp_q[$], e;
    always #10 i_mclk = ~i_mclk;
    mtd_audio_model u_adc (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_tone_on(tone),
        .o_smp_valid(smp_valid), .o_smp_data(smp_data));
    mtd_decoder DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_smp_valid(smp_valid),
        .i_smp_data(smp_data), .i_key_down(i_key_down), .o_chr_valid(o_chr_valid),
        .o_chr(o_chr), .i_chr_ready(i_chr_ready), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
        .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
        .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack));
    ////////////////////////////////////////
    task automatic conclude();
        $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : conclude
    always @(posedge i_mclk) begin
        cycles <= cycles + 1;
        i_chr_ready <= hold ? 1'b0 : 1'($random(seed));
        if (o_chr_valid === 1'b1 && i_chr_ready === 1'b1) begin
            e = exp_q.size() ? exp_q.pop_front() : 9'h1ff;
            `CHK("chr", e, o_chr)
        end
        if (cycles == 100000) begin
            n_mismatch++;
            conclude();
        end
    end
    ////////////////////////////////////////
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [3:0] s);
        @(posedge i_mclk);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we <= w;
        i_wb_adr <= a;
        i_wb_dat <= {24'($random(seed)), d[7:0]};
        i_wb_sel <= {3'($random(seed)), s[0]};
        do begin
            @(posedge i_mclk);
        end while (o_wb_ack !== 1'b1);
        q = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
    endtask : wb
    task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
        wb(1'b0, a, 32'h0, 4'hf);
        `CHK(nm, x, q)
    endtask : rd
    task automatic key(input bit rx, input int on, input int off);
        @(posedge i_mclk);
        if (rx) tone <= on > 0; else i_key_down <= on > 0;
        repeat (on * TICK) @(posedge i_mclk);
        tone <= 1'b0;
        i_key_down <= 1'b0;
        repeat (off * TICK) @(posedge i_mclk);
    endtask : key
    task automatic drain();
        while (exp_q.size() > 0) begin
            @(posedge i_mclk);
        end
    endtask : drain
    // Threshold step seen across exactly one tick
    task automatic thr_chk();
        logic [31:0] t0, t1, a;
        int n;
        wb(1'b0, `MTD_OFF_THRESH, 32'h0, 4'hf);
        n = 0;
        do begin
            t0 = q;
            wb(1'b0, `MTD_OFF_THRESH, 32'h0, 4'hf);
            t1 = q;
            wb(1'b0, `MTD_OFF_AMPL, 32'h0, 4'hf);
            a = q;
            wb(1'b0, `MTD_OFF_THRESH, 32'h0, 4'hf);
            n++;
        end while ((t1 === t0 || q !== t1) && n < 40);
        `CHK("thresh", 32'(int'(t0) + (int'(a) - int'(t0)) / int'(`MTD_RST_AMPAVG)), t1)
    endtask : thr_chk
    ////////////////////////////////////////
    initial begin
        repeat (8) @(posedge i_mclk);
        i_rst_n <= !i_rst_n;
        rd(`MTD_OFF_CTRL, 32'(`MTD_RST_CTRL), "ctrl");
        rd(`MTD_OFF_MODE, 32'(`MTD_RST_MODE), "mode");
        rd(`MTD_OFF_SPDAVG, 32'(`MTD_RST_SPDAVG), "spdavg");
        rd(`MTD_OFF_AMPAVG, 32'(`MTD_RST_AMPAVG), "ampavg");
        rd(`MTD_OFF_DOT, 32'(`MTD_DOT_MS_WPM / `MTD_RST_WPM), "dot");
        rd(8'h40, 32'h0, "unmapped");
        wb(1'b1, `MTD_OFF_BLANK, 32'h0, 4'h0);
        rd(`MTD_OFF_BLANK, 32'(`MTD_RST_BLANK), "blank");
        wb(1'b1, `MTD_OFF_WPM, 32'hc8, 4'h1);
        wb(1'b1, `MTD_OFF_MODE, 32'h1, 4'h1);
        rd(`MTD_OFF_DOT, 32'(`MTD_DOT_MS_WPM / `MTD_WPM_MAX), "dot_clamp");
        wb(1'b1, `MTD_OFF_MODE, 32'h0, 4'h1);
        wb(1'b1, `MTD_OFF_WPM, 32'h3c, 4'h1);
        wb(1'b1, `MTD_OFF_MODE, 32'h1, 4'h1);
        rd(`MTD_OFF_DOT, 32'(`MTD_DOT_MS_WPM / 24'h3c), "dot_seed");
        exp_q.push_back(9'h005);
        exp_q.push_back(9'h001);
        key(0, 1, 30);
        key(0, 8, 5);
        key(0, 15, 40);
        drain();
        rd(`MTD_OFF_DOT, 32'(20 + (8 * 4 - 20) / `MTD_RST_SPDAVG), "dot_ema");
        // Consumer stalled: four queued, one pending, rest dropped
        hold = 1'b1;
        repeat (5) exp_q.push_back(9'h002);
        repeat (6) key(0, 5, 15);
        key(0, 0, 30);
        wb(1'b0, `MTD_OFF_STATUS, 32'h0, 4'hf);
        `CHK("ovf", 1'b1, q[`MTD_STAT_OVF])
        hold = 1'b0;
        drain();
        wb(1'b1, `MTD_OFF_STATUS, 32'h4, 4'h1);
        wb(1'b0, `MTD_OFF_STATUS, 32'h0, 4'hf);
        `CHK("ovf_clr", 1'b0, q[`MTD_STAT_OVF])
        wb(1'b1, `MTD_OFF_CTRL, 32'h5, 4'h1);
        key(0, 5, 40);
        wb(1'b1, `MTD_OFF_CTRL, 32'h7, 4'h1);
        wb(1'b1, `MTD_OFF_MODE, 32'h2, 4'h1);
        exp_q.push_back(9'h102);
        exp_q.push_back(9'h101);
        key(0, 5, 40);
        drain();
        wb(1'b1, `MTD_OFF_MODE, 32'h0, 4'h1);
        wb(1'b1, `MTD_OFF_CTRL, 32'h0, 4'h1);
        @(posedge i_mclk);
        tone <= 1'b1;
        repeat (2 * TICK) @(posedge i_mclk);
        thr_chk();
        key(1, 3, 40);
        wb(1'b1, `MTD_OFF_CTRL, 32'h1, 4'h1);
        exp_q.push_back(9'h002);
        exp_q.push_back(9'h001);
        key(1, 5, 40);
        drain();
        `CHK("left", 0, exp_q.size())
        conclude();
    end
endmodule : mtd_decoder_bench
`default_nettype wire
